// ---- rtl/sce_consts.svh ----
`ifndef SCE_CONSTS_SVH
`define SCE_CONSTS_SVH
// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define SCE_ADR_CTRL     4'h0
`define SCE_ADR_MODE     4'h4
`define SCE_ADR_RXDATA   4'h8
`define SCE_ADR_STATUS   4'hc
// ---------------------------------------------------------------
// serial_control fields
// ---------------------------------------------------------------
`define SCE_CTRL_RESET   8'h00
`define SCE_BIT_TXE_IE   7
`define SCE_BIT_RX_IE    6
`define SCE_BIT_TX_EN    5
`define SCE_BIT_RX_EN    4
`define SCE_BIT_SKIP     3
`define SCE_BIT_TXEND_IE 2
`define SCE_BIT_CKS_HI   1
`define SCE_BIT_CKS_LO   0
// ---------------------------------------------------------------
// mode, status and receive data fields
// ---------------------------------------------------------------
`define SCE_BIT_COM      1
`define SCE_BIT_MPMODE   0
`define SCE_BIT_RXNE     0
`define SCE_BIT_FER      1
`define SCE_BIT_OER      2
`define SCE_BIT_SKIPACT  3
`define SCE_BIT_PIN      4
`define SCE_BIT_RXMPB    8
// ---------------------------------------------------------------
// clock timing
// ---------------------------------------------------------------
`define SCE_OVERSAMPLE   16
`define SCE_HALF_BIT_MAX 3'd7
`endif

// ---- rtl/sce_pkg.sv ----
package sce_pkg;
    typedef enum logic [1:0] {
        SCE_CK_INT     = 2'b00,
        SCE_CK_INT_OUT = 2'b01,
        SCE_CK_EXT     = 2'b10,
        SCE_CK_RSVD    = 2'b11
    } sce_cks_e;

    typedef struct packed {
        logic [7:0]  ctrl;
        logic        com;
        logic        mp;
        logic        ack;
        logic [31:0] dat;
        logic        framing_error_flag;
        logic        overrun_flag;
        logic [2:0]  sync;
        logic        pin;
        logic [2:0]  div;
        logic        sck;
        logic        sck_oe;
        logic        tx_tick;
        logic        rx_tick;
        logic        rx_ready;
        logic [3:0]  irq;
    } sce_state_s;
endpackage : sce_pkg

// ---- rtl/sce_serial_control.sv ----
// Contract
// - transmit-empty request passes only with its enable
// - receive-full and error pass only with rx interrupt enable
// - transmission runs only while transmit enabled
// - reception runs only while receive enabled
// - skip enable acts only async multiprocessor mode
// - skipping drops mp-0 characters, blocks flag setting
// - mp-1 character clears skip enable, resumes reception
// - transmit-end request passes only with its enable
// - async 00 uses baud generator, pin unused
// - async 01 drives bit-rate clock on pin
// - async 10 takes sixteen-times clock from pin
// - synchronous 00 drives internal clock on pin
// - synchronous 10 takes transfer clock from pin
// - mode bit picks async or synchronous
// - multiprocessor mode bit enables address filtering
`timescale 1ns/100ps
`include "sce_consts.svh"

// ---------------------------------------------------------------
// receive buffer
// ---------------------------------------------------------------
module sce_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o,
    output logic [$clog2(DEPTH):0] count_o
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("sce_fifo depth must be a power of two, at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } sce_fifo_s;

    sce_fifo_s s;
    sce_fifo_s next_s;
    logic      push;
    logic      pop;

    always_comb
    begin
        next_s = s;
        push   = in_valid_i && (s.cnt != DEPTH[AW:0]);
        pop    = out_ready_i && (s.cnt != '0);
        if (push)
        begin
            next_s.mem[s.wp] = in_data_i;
            next_s.wp        = s.wp + 1'b1;
        end
        if (pop)
        begin
            next_s.rp = s.rp + 1'b1;
        end
        // wraps cleanly because depth is a power of two
        next_s.cnt = s.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign in_ready_o  = (s.cnt != DEPTH[AW:0]);
    assign out_valid_o = (s.cnt != '0);
    assign out_data_o  = s.mem[s.rp];
    assign count_o     = s.cnt;
endmodule : sce_fifo

// ---------------------------------------------------------------
// control register, request gating and serial clock selection
// ---------------------------------------------------------------
module sce_serial_control #(
    parameter int RX_DEPTH = 8
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        brg_tick_i,
    input  wire logic        sck_in_i,
    output logic             sck_out_o,
    output logic             sck_oe_o,
    output logic             tx_tick_o,
    output logic             rx_tick_o,
    output logic             tx_enable_o,
    output logic             rx_enable_o,
    input  wire logic        rx_valid_i,
    output logic             rx_ready_o,
    input  wire logic [7:0]  rx_data_i,
    input  wire logic        rx_mpb_i,
    input  wire logic        rx_fer_i,
    input  wire logic        rx_oer_i,
    input  wire logic        tx_empty_request_i,
    input  wire logic        tx_end_request_i,
    output logic             tx_empty_request_o,
    output logic             rx_full_request_o,
    output logic             rx_error_request_o,
    output logic             tx_end_request_o
);
    localparam int CW = $clog2(RX_DEPTH);

    if (RX_DEPTH < 2 || RX_DEPTH > 256)
    begin : g_bad_depth
        $error("sce_serial_control receive depth out of range");
    end

    sce_pkg::sce_state_s s;
    sce_pkg::sce_state_s next_s;
    sce_pkg::sce_cks_e   cks;

    logic        req;
    logic        wr;
    logic        skip_act;
    logic        accept;
    logic        push;
    logic        pop;
    logic        ext_rise;
    logic        fifo_valid;
    logic [8:0]  fifo_data;
    logic [CW:0] fifo_cnt;
    logic [CW:0] cnt_after;

    sce_fifo #(
        .WIDTH (9),
        .DEPTH (RX_DEPTH)
    ) u_rx_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (push),
        .in_ready_o  (),
        .in_data_i   ({rx_mpb_i, rx_data_i}),
        .out_valid_o (fifo_valid),
        .out_ready_i (pop),
        .out_data_o  (fifo_data),
        .count_o     (fifo_cnt)
    );

    always_comb
    begin
        next_s = s;
        req    = wb_cyc_i && wb_stb_i && !s.ack;
        wr     = req && wb_we_i && wb_sel_i[0];
        cks    = sce_pkg::sce_cks_e'(s.ctrl[`SCE_BIT_CKS_HI:`SCE_BIT_CKS_LO]);

        // ---------------------------------------------------------
        // receive filtering
        // ---------------------------------------------------------
        // skipping only counts in async multiprocessor mode
        skip_act = s.ctrl[`SCE_BIT_SKIP] && s.mp && !s.com;
        accept   = rx_valid_i && s.rx_ready;
        push     = accept && !(skip_act && !rx_mpb_i);
        if (accept && skip_act && rx_mpb_i)
        begin
            next_s.ctrl[`SCE_BIT_SKIP] = 1'b0;
        end
        pop = req && !wb_we_i && (wb_adr_i == `SCE_ADR_RXDATA)
            && fifo_valid;
        cnt_after = fifo_cnt + {{CW{1'b0}}, push}
                  - {{CW{1'b0}}, pop};
        // registered ready leaves no room for a combinational race
        next_s.rx_ready = s.ctrl[`SCE_BIT_RX_EN]
            && (cnt_after != RX_DEPTH[CW:0]);

        // error flags: a new error wins over a same-cycle clear
        if (wr && wb_adr_i == `SCE_ADR_STATUS)
        begin
            next_s.framing_error_flag = s.framing_error_flag && !wb_dat_i[`SCE_BIT_FER];
            next_s.overrun_flag = s.overrun_flag && !wb_dat_i[`SCE_BIT_OER];
        end
        if (s.ctrl[`SCE_BIT_RX_EN] && !skip_act)
        begin
            next_s.framing_error_flag = next_s.framing_error_flag || rx_fer_i;
            next_s.overrun_flag = next_s.overrun_flag || rx_oer_i;
        end

        // ---------------------------------------------------------
        // bus slave
        // ---------------------------------------------------------
        next_s.ack = req;
        if (wr && wb_adr_i == `SCE_ADR_CTRL)
        begin
            // a software write overrides the same-cycle auto clear
            next_s.ctrl = wb_dat_i[7:0];
        end
        if (wr && wb_adr_i == `SCE_ADR_MODE)
        begin
            next_s.com = wb_dat_i[`SCE_BIT_COM];
            next_s.mp  = wb_dat_i[`SCE_BIT_MPMODE];
        end
        if (req)
        begin
            next_s.dat = 32'h0000_0000;
            case (wb_adr_i)
                `SCE_ADR_CTRL:
                begin
                    next_s.dat[7:0] = s.ctrl;
                end
                `SCE_ADR_MODE:
                begin
                    next_s.dat[`SCE_BIT_COM]    = s.com;
                    next_s.dat[`SCE_BIT_MPMODE] = s.mp;
                end
                `SCE_ADR_RXDATA:
                begin
                    next_s.dat[8:0] = fifo_valid ? fifo_data : 9'h000;
                end
                `SCE_ADR_STATUS:
                begin
                    next_s.dat[`SCE_BIT_RXNE]    = fifo_valid;
                    next_s.dat[`SCE_BIT_FER]     = s.framing_error_flag;
                    next_s.dat[`SCE_BIT_OER]     = s.overrun_flag;
                    next_s.dat[`SCE_BIT_SKIPACT] = skip_act;
                    next_s.dat[`SCE_BIT_PIN]     = s.pin;
                end
                default:
                begin
                    next_s.dat = 32'h0000_0000;
                end
            endcase
        end

        // ---------------------------------------------------------
        // serial clock pin and bit clock
        // ---------------------------------------------------------
        // the first stage feeds only the second
        next_s.sync = {s.sync[1:0], sck_in_i};
        if (s.sync[2] == s.sync[1])
        begin
            next_s.pin = s.sync[1];
        end
        ext_rise = (s.sync[2] == s.sync[1]) && s.sync[1] && !s.pin;

        next_s.sck_oe  = 1'b0;
        next_s.tx_tick = 1'b0;
        next_s.rx_tick = 1'b0;
        if (!s.com)
        begin
            case (cks)
                sce_pkg::SCE_CK_INT:
                begin
                    next_s.rx_tick = brg_tick_i;
                end
                sce_pkg::SCE_CK_INT_OUT:
                begin
                    next_s.rx_tick = brg_tick_i;
                    next_s.sck_oe  = 1'b1;
                    if (brg_tick_i)
                    begin
                        next_s.div = s.div + 3'd1;
                        // eight oversample ticks per half bit
                        if (s.div == `SCE_HALF_BIT_MAX)
                        begin
                            next_s.sck = !s.sck;
                        end
                    end
                end
                sce_pkg::SCE_CK_EXT:
                begin
                    next_s.rx_tick = ext_rise;
                end
                default:
                begin
                    // reserved select gives no clock
                    next_s.rx_tick = 1'b0;
                end
            endcase
            next_s.tx_tick = next_s.rx_tick;
        end
        else
        begin
            case (cks)
                sce_pkg::SCE_CK_INT:
                begin
                    next_s.sck_oe = 1'b1;
                    if (brg_tick_i)
                    begin
                        next_s.sck     = !s.sck;
                        next_s.rx_tick = !s.sck;
                    end
                end
                sce_pkg::SCE_CK_EXT:
                begin
                    next_s.rx_tick = ext_rise;
                end
                default:
                begin
                    next_s.rx_tick = 1'b0;
                end
            endcase
            next_s.tx_tick = next_s.rx_tick;
        end
        if (!next_s.sck_oe)
        begin
            next_s.sck = 1'b0;
            next_s.div = 3'd0;
        end
        next_s.tx_tick = next_s.tx_tick
            && next_s.ctrl[`SCE_BIT_TX_EN];
        next_s.rx_tick = next_s.rx_tick
            && next_s.ctrl[`SCE_BIT_RX_EN];

        // ---------------------------------------------------------
        // request gating
        // ---------------------------------------------------------
        next_s.irq[3] = next_s.ctrl[`SCE_BIT_TXE_IE]
            && tx_empty_request_i;
        next_s.irq[2] = next_s.ctrl[`SCE_BIT_RX_IE]
            && (fifo_valid || push);
        next_s.irq[1] = next_s.ctrl[`SCE_BIT_RX_IE]
            && (next_s.framing_error_flag || next_s.overrun_flag);
        next_s.irq[0] = next_s.ctrl[`SCE_BIT_TXEND_IE]
            && tx_end_request_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign wb_dat_o           = s.dat;
    assign wb_ack_o           = s.ack;
    assign sck_out_o          = s.sck;
    assign sck_oe_o           = s.sck_oe;
    assign tx_tick_o          = s.tx_tick;
    assign rx_tick_o          = s.rx_tick;
    assign tx_enable_o        = s.ctrl[`SCE_BIT_TX_EN];
    assign rx_enable_o        = s.ctrl[`SCE_BIT_RX_EN];
    assign rx_ready_o         = s.rx_ready;
    assign tx_empty_request_o = s.irq[3];
    assign rx_full_request_o  = s.irq[2];
    assign rx_error_request_o = s.irq[1];
    assign tx_end_request_o   = s.irq[0];
endmodule : sce_serial_control

// ---- tb/sce_partner.sv ----
`timescale 1ns/100ps
module sce_partner (
    input  wire logic clk_i,
    input  wire logic run_i,
    input  wire logic oe_i,
    input  wire logic out_i,
    output logic      pin_o
);
    logic [1:0] ph = 2'h0;
    // clock only within a transfer, still low in between
    always @(posedge clk_i)
        ph <= run_i ? ph + 2'h1 : 2'h0;
    assign pin_o = oe_i ? out_i : ph[1];
endmodule : sce_partner

// ---- tb/sce_serial_control_checker.sv ----
`timescale 1ns/100ps
module sce_serial_control_checker #(
    parameter int RX_DEPTH = 8
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic        sck_oe_o,
    input wire logic        tx_tick_o,
    input wire logic        rx_tick_o,
    input wire logic        tx_enable_o,
    input wire logic        rx_enable_o,
    input wire logic        rx_ready_o,
    input wire logic        tx_empty_request_i,
    input wire logic        tx_end_request_i,
    input wire logic        tx_empty_request_o,
    input wire logic        rx_full_request_o,
    input wire logic        rx_error_request_o,
    input wire logic        tx_end_request_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [7:0] sh;
    logic [1:0] md;
    logic       wr;
    logic [7:0] shn;
    // shadow copy; bit 3 may self-clear, so it is never used
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
    // gating registers the value being written in the same cycle
    assign shn = (wr && wb_adr_i == 4'h0) ? wb_dat_i[7:0] : sh;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            {sh, md} <= 10'h000;
        else if (wr && wb_adr_i == 4'h0)
            sh <= wb_dat_i[7:0];
        else if (wr && wb_adr_i == 4'h4)
            md <= wb_dat_i[1:0];
    end
    chk_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one pulse");
    chk_txe_gate: assert property (!$past(rst_i) |-> tx_empty_request_o ==
        $past(tx_empty_request_i && shn[7])) else $error("tx empty gate");
    chk_rx_gate: assert property (!$past(rst_i) && !$past(shn[6]) |->
        !rx_full_request_o && !rx_error_request_o) else $error("rx gate");
    chk_tend_gate: assert property (!$past(rst_i) |-> tx_end_request_o ==
        $past(tx_end_request_i && shn[2])) else $error("tx end gate");
    chk_en_levels: assert property (tx_enable_o == sh[5] &&
        rx_enable_o == sh[4]) else $error("enable levels");
    chk_tx_quiet: assert property (!sh[5] && !$past(sh[5]) |->
        !tx_tick_o) else $error("tx tick while disabled");
    chk_rx_quiet: assert property (!sh[4] && !$past(sh[4]) |->
        !rx_tick_o && !rx_ready_o) else $error("rx active while disabled");
    chk_pin_input: assert property ((sh[1:0] == 2'b10 ||
        (!md[1] && sh[1:0] == 2'b00)) && $stable(sh) && $stable(md)
        |-> !sck_oe_o) else $error("pin driven as input");
    chk_pin_drive: assert property (((!md[1] && sh[1:0] == 2'b01) ||
        (md[1] && sh[1:0] == 2'b00)) && $stable(sh) && $stable(md)
        && !$past(rst_i) |-> sck_oe_o) else $error("pin not driven");
endmodule : sce_serial_control_checker
bind sce_serial_control sce_serial_control_checker #(.RX_DEPTH(RX_DEPTH))
    u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_ack_o, .sck_oe_o, .tx_tick_o, .rx_tick_o,
    .tx_enable_o, .rx_enable_o, .rx_ready_o, .tx_empty_request_i,
    .tx_end_request_i, .tx_empty_request_o, .rx_full_request_o,
    .rx_error_request_o, .tx_end_request_o);

// ---- tb/sce_serial_control_test.sv ----
`timescale 1ns/100ps
module sce_serial_control_test;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [3:0]  wb_adr_i, wb_sel_i, e;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic        brg_tick_i, sck_pin, sck_out_o, sck_oe_o, run;
    logic        tx_tick_o, rx_tick_o, tx_enable_o, rx_enable_o;
    logic        rx_valid_i, rx_ready_o, rx_mpb_i, rx_fer_i, rx_oer_i;
    logic [7:0]  rx_data_i, c;
    logic        tx_empty_request_i, tx_end_request_i, tx_empty_request_o;
    logic        rx_full_request_o, rx_error_request_o, tx_end_request_o;
    logic [1:0]  bc = 2'h0;
    logic [8:0]  w [8];
    logic [3:0]  tbl [5] = '{4'h0, 4'h3, 4'h4, 4'h9, 4'hc};
    logic [1:0]  mt [3] = '{2'b01, 2'b00, 2'b11};
    int          i, n, m, t, err_total, check_count;
    sce_serial_control #(.RX_DEPTH(8)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .brg_tick_i(brg_tick_i),
        .sck_in_i(sck_pin), .sck_out_o(sck_out_o), .sck_oe_o(sck_oe_o),
        .tx_tick_o(tx_tick_o), .rx_tick_o(rx_tick_o),
        .tx_enable_o(tx_enable_o), .rx_enable_o(rx_enable_o),
        .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o),
        .rx_data_i(rx_data_i), .rx_mpb_i(rx_mpb_i), .rx_fer_i(rx_fer_i),
        .rx_oer_i(rx_oer_i), .tx_empty_request_i(tx_empty_request_i),
        .tx_end_request_i(tx_end_request_i),
        .tx_empty_request_o(tx_empty_request_o),
        .rx_full_request_o(rx_full_request_o),
        .rx_error_request_o(rx_error_request_o),
        .tx_end_request_o(tx_end_request_o));
    sce_partner u_far (.clk_i(clk_i), .run_i(run), .oe_i(sck_oe_o),
        .out_i(sck_out_o), .pin_o(sck_pin));
    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        bc <= bc + 2'h1;
        brg_tick_i <= (bc == 2'h3);
    end
    task report_and_stop;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop
    task chk(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x)
        begin
            err_total++;
            $display("wrong value at %0t got %h exp %h", $time, g, x);
        end
    endtask : chk
    task chkb(input logic g, input logic x);
        chk({31'h0, g}, {31'h0, x});
    endtask : chkb
    // master waits for ack with no assumed latency
    task wb(input logic we, input logic [3:0] a, input logic [31:0] d,
            input logic [3:0] s);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
        {wb_adr_i, wb_dat_i, wb_sel_i} <= {a, d, s};
        // only the watchdog ends a wait that never gets an answer
        do begin @(posedge clk_i); end
        while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge clk_i);
    endtask : wb
    task push(input logic [8:0] x);
        {rx_valid_i, rx_mpb_i, rx_data_i} <= {1'b1, x};
        do begin @(posedge clk_i); end
        while (rx_ready_o !== 1'b1);
        rx_valid_i <= 1'b0;
        @(posedge clk_i);
    endtask : push
    initial
    begin
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, run} = 5'h10;
        {wb_adr_i, wb_sel_i, wb_dat_i, brg_tick_i} = 41'h0;
        {rx_valid_i, rx_mpb_i, rx_data_i, rx_fer_i, rx_oer_i} = 12'h0;
        {tx_empty_request_i, tx_end_request_i, err_total, check_count} = 0;
        void'($urandom(12));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(0, 4'h0, 0, 4'hf); chk(rd, 32'h0);
        wb(1, 4'h2, 32'hff, 4'hf); wb(0, 4'h2, 0, 4'hf); chk(rd, 32'h0);
        wb(1, 4'h0, 32'hff, 4'he); wb(0, 4'h0, 0, 4'hf); chk(rd, 32'h0);
        $display("test registers done");
        for (i = 0; i < 12; i++)
        begin
            c = 8'($urandom);
            if (c[1:0] == 2'b11) c[0] = 1'b0;
            wb(1, 4'h0, {24'h0, c}, 4'hf);
            wb(0, 4'h0, 0, 4'hf); chk(rd, {24'h0, c});
            tx_empty_request_i <= 1'($urandom);
            tx_end_request_i <= 1'($urandom);
            repeat (3) @(posedge clk_i);
            chkb(tx_empty_request_o, tx_empty_request_i & c[7]);
            chkb(tx_end_request_o, tx_end_request_i & c[2]);
            chk({30'h0, tx_enable_o, rx_enable_o}, {30'h0, c[5:4]});
        end
        $display("test gating done");
        // last row has both enables off: no ticks expected
        for (i = 0; i < 6; i++)
        begin
            e = (i < 5) ? tbl[i] : 4'h0;
            wb(1, 4'h4, {30'h0, e[3], 1'b0}, 4'hf);
            wb(1, 4'h0, {24'h0, (i < 5) ? 4'h3 : 4'h0, 2'h0, e[2:1]}, 4'hf);
            run <= e[2];
            n = 0;
            m = 0;
            t = 0;
            repeat (64)
            begin
                @(posedge clk_i);
                n += (rx_tick_o === 1'b1);
                t += (tx_tick_o === 1'b1);
                m += (sck_out_o === 1'b1);
            end
            chkb(sck_oe_o, e[0]);
            chkb(n > 0, i < 5);
            chkb(t > 0, i < 5);
            chkb(m > 0, e[0]);
            run <= 1'b0;
        end
        $display("test clock select done");
        for (i = 0; i < 3; i++)
        begin
            wb(1, 4'h4, {30'h0, mt[i]}, 4'hf); wb(1, 4'h0, 32'h58, 4'hf);
            push(9'h055);
            rx_fer_i <= 1'b1; @(posedge clk_i); rx_fer_i <= 1'b0;
            repeat (3) @(posedge clk_i);
            chkb(rx_full_request_o, mt[i] != 2'b01);
            chkb(rx_error_request_o, mt[i] != 2'b01);
            wb(0, 4'hc, 0, 4'hf);
            chk(rd & 32'h3, (mt[i] == 2'b01) ? 0 : 3);
            wb(1, 4'hc, 32'h6, 4'hf);
            push(9'h1aa); repeat (3) @(posedge clk_i);
            chkb(rx_full_request_o, 1'b1);
            chkb(rx_error_request_o, 1'b0);
            if (mt[i] != 2'b01) begin wb(0, 4'h8, 0, 4'hf); chk(rd, 32'h055); end
            wb(0, 4'h8, 0, 4'hf); chk(rd, 32'h1aa);
            wb(0, 4'h0, 0, 4'hf);
            chk(rd, (mt[i] == 2'b01) ? 32'h50 : 32'h58);
        end
        $display("test skip done");
        wb(1, 4'h4, 0, 4'hf); wb(1, 4'h0, 32'h10, 4'hf);
        for (i = 0; i < 8; i++) begin w[i] = 9'($urandom); push(w[i]); end
        @(posedge clk_i); chkb(rx_ready_o, 1'b0);
        for (i = 0; i < 8; i++) begin wb(0, 4'h8, 0, 4'hf); chk(rd, {23'h0, w[i]}); end
        wb(0, 4'hc, 0, 4'hf); chk(rd & 32'h1, 32'h0);
        $display("test buffer done");
        report_and_stop;
    end
    initial
    begin
        repeat (6000) @(posedge clk_i);
        err_total++;
        report_and_stop;
    end
endmodule : sce_serial_control_test
